// file: src/smc_pkg.sv
package smc_pkg;

  // Sleep mode select encoding, three bits
  localparam logic [2:0] MODE_IDLE     = 3'h0;
  localparam logic [2:0] MODE_PDOWN    = 3'h2;
  localparam logic [2:0] MODE_PSAVE    = 3'h3;
  localparam logic [2:0] MODE_STANDBY  = 3'h6;
  localparam logic [2:0] MODE_XSTANDBY = 3'h7;

  // Wake source vector bit positions
  localparam int WK_W         = 4;
  localparam int WK_PERIPH    = 0;
  localparam int WK_TWI_ADDR  = 1;
  localparam int WK_PORT_ASYN = 2;
  localparam int WK_USB_RES   = 3;

  // Wake sources that survive power-down
  localparam logic [3:0] PDOWN_WAKE_MASK = 4'hE;
  localparam logic [3:0] ALL_WAKE_MASK   = 4'hF;

  // Restart stall after wake, cycles
  localparam int STALL_CYCLES = 4;

  // Clock-domain gating bundle
  typedef struct packed {
    logic cpu_run;
    logic nvm_run;
    logic per_run;
    logic async_run;
    logic rtc_run;
  } smc_clk_t;

  localparam smc_clk_t CLK_ALL_ON = 5'h1F;

endpackage

// file: src/smc_sleep_ctrl.sv
`timescale 1ns/1ps

// How it works
// - Sleep instruction enters the selected sleep mode
// - Five modes, each gating different clock sets
// - Wake sources gated by configured sleep mode
// - Wake runs the ISR, then next instruction
// - Pending higher-priority interrupts serviced first
// - Core stalled four cycles after every wake
// - Register file, SRAM, registers retained asleep
// - Reset in sleep aborts and restarts vector
// - Idle stops CPU and nonvolatile memory clocks
// - Ongoing NVM programming finishes before stop
// - Idle keeps peripherals running, any interrupt wakes
// - Power-down stops every clock including RTC
// - Power-down wakes on TWI, async port, USB
// - Enter from active; interrupt or reset returns
module smc_sleep_ctrl (
  // Clock and reset
  input  wire logic             SYS_CLK,
  input  wire logic             SYS_RST,
  // Core side
  input  wire logic             SLEEP_EXEC,
  input  wire logic [2:0]       SLEEP_MODE,
  input  wire logic             SLEEP_EN,
  output logic                  CPU_HOLD,
  output logic                  SLEEP_ACTIVE,
  output logic [2:0]            SLEEP_MODE_CUR,
  // Interrupt controller side
  input  wire logic [3:0]       WAKE_REQ,
  output logic                  WAKE_PULSE,
  // Nonvolatile memory
  input  wire logic             NVM_BUSY,
  // Clock generator
  output smc_pkg::smc_clk_t     CLK_GATE,
  input  wire logic             CLK_READY
);

  typedef enum logic [2:0] {
    ST_ACTIVE, ST_NVM_WAIT, ST_SLEEP, ST_CLK_WAIT, ST_STALL
  } smc_state_t;

  smc_state_t        state_q;
  smc_state_t        state_d;
  logic [2:0]        mode_q;
  logic [2:0]        mode_d;
  smc_pkg::smc_clk_t gate_q;
  smc_pkg::smc_clk_t gate_d;
  logic              wake_q;
  logic              wake_d;
  logic [3:0]        wake_mask;
  logic              wake_hit;
  logic              stall_start;
  logic              stall_busy;
  logic              stall_done;

  // Wake sources allowed by the latched mode
  always_comb begin
    unique case (mode_q)
      smc_pkg::MODE_IDLE: wake_mask = smc_pkg::ALL_WAKE_MASK;
      smc_pkg::MODE_PDOWN: wake_mask = smc_pkg::PDOWN_WAKE_MASK;
      // Other modes keep the same async set as power-down
      default: wake_mask = smc_pkg::PDOWN_WAKE_MASK;
    endcase
  end

  assign wake_hit = |(WAKE_REQ & wake_mask);

  // Clock set stopped in each mode while asleep
  function automatic smc_pkg::smc_clk_t sleep_gates(input logic [2:0] m);
    smc_pkg::smc_clk_t g;
    g = smc_pkg::CLK_ALL_ON;
    g.cpu_run = 1'b0;
    g.nvm_run = 1'b0;
    unique case (m)
      smc_pkg::MODE_IDLE: begin
      end
      smc_pkg::MODE_PDOWN: begin
        g.per_run   = 1'b0;
        g.async_run = 1'b0;
        g.rtc_run   = 1'b0;
      end
      smc_pkg::MODE_PSAVE: begin
        g.per_run   = 1'b0;
        g.async_run = 1'b0;
      end
      // Extended standby keeps async and RTC so it differs from save
      smc_pkg::MODE_XSTANDBY: begin
        g.per_run = 1'b0;
      end
      smc_pkg::MODE_STANDBY: begin
        g.per_run = 1'b0;
        g.rtc_run = 1'b0;
      end
      default: begin
        g.per_run   = 1'b0;
        g.async_run = 1'b0;
        g.rtc_run   = 1'b0;
      end
    endcase
    return g;
  endfunction

  // Sequencer next state; clocks are only gated, never reset,
  // so all storage keeps its contents across sleep
  always_comb begin
    state_d     = state_q;
    mode_d      = mode_q;
    gate_d      = gate_q;
    wake_d      = 1'b0;
    stall_start = 1'b0;
    unique case (state_q)
      ST_ACTIVE: begin
        if (SLEEP_EXEC && SLEEP_EN) begin
          mode_d = SLEEP_MODE;
          if (NVM_BUSY) begin
            gate_d.cpu_run = 1'b0;
            state_d = ST_NVM_WAIT;
          end else begin
            gate_d  = sleep_gates(SLEEP_MODE);
            state_d = ST_SLEEP;
          end
        end
      end
      ST_NVM_WAIT: begin
        // Wake may come before programming ends
        if (wake_hit) begin
          gate_d  = smc_pkg::CLK_ALL_ON;
          state_d = ST_CLK_WAIT;
        end else if (!NVM_BUSY) begin
          gate_d  = sleep_gates(mode_q);
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_hit) begin
          gate_d  = smc_pkg::CLK_ALL_ON;
          state_d = ST_CLK_WAIT;
        end
      end
      ST_CLK_WAIT: begin
        if (CLK_READY) begin
          stall_start = 1'b1;
          state_d     = ST_STALL;
        end
      end
      ST_STALL: begin
        if (stall_done) begin
          wake_d  = 1'b1;
          state_d = ST_ACTIVE;
        end
      end
    endcase
  end

  // Sync reset returns straight to active and vector
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_q <= ST_ACTIVE;
      mode_q  <= smc_pkg::MODE_IDLE;
      gate_q  <= smc_pkg::CLK_ALL_ON;
      wake_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q  <= mode_d;
      gate_q  <= gate_d;
      wake_q  <= wake_d;
    end
  end

  smc_stall_cnt #(
    .CYCLES (smc_pkg::STALL_CYCLES)
  ) u_stall (
    .clk   (SYS_CLK),
    .rst   (SYS_RST),
    .start (stall_start),
    .busy  (stall_busy),
    .done  (stall_done)
  );

  // Core held from entry until the stall expires
  assign CPU_HOLD       = (state_q != ST_ACTIVE);
  assign SLEEP_ACTIVE   = (state_q == ST_SLEEP);
  assign SLEEP_MODE_CUR = mode_q;
  assign WAKE_PULSE     = wake_q;
  assign CLK_GATE       = gate_q;

  // Checks
  property p_stall_len;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    stall_start |=> CPU_HOLD [*4] ##1 !CPU_HOLD;
  endproperty
  a_stall_len: assert property (p_stall_len)
    else $error("stall not four cycles");

  property p_noop;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (state_q == ST_ACTIVE && SLEEP_EXEC && !SLEEP_EN) |=> !CPU_HOLD;
  endproperty
  a_noop: assert property (p_noop)
    else $error("sleep taken while disabled");

  property p_idle_gate;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (SLEEP_ACTIVE && mode_q == smc_pkg::MODE_IDLE)
      |-> (!CLK_GATE.cpu_run && !CLK_GATE.nvm_run && CLK_GATE.per_run);
  endproperty
  a_idle_gate: assert property (p_idle_gate)
    else $error("idle gating wrong");

  property p_pdown_gate;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (SLEEP_ACTIVE && mode_q == smc_pkg::MODE_PDOWN)
      |-> (CLK_GATE == '0);
  endproperty
  a_pdown_gate: assert property (p_pdown_gate)
    else $error("power-down left a clock running");

  property p_pdown_wake;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (SLEEP_ACTIVE && mode_q == smc_pkg::MODE_PDOWN
     && WAKE_REQ == 4'h1) |=> SLEEP_ACTIVE;
  endproperty
  a_pdown_wake: assert property (p_pdown_wake)
    else $error("peripheral woke power-down");

  property p_idle_wake;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (SLEEP_ACTIVE && mode_q == smc_pkg::MODE_IDLE && |WAKE_REQ)
      |=> (state_q == ST_CLK_WAIT && CLK_GATE == smc_pkg::CLK_ALL_ON);
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("idle did not wake");

  property p_nvm_wait;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (state_q == ST_NVM_WAIT) |-> CLK_GATE.nvm_run;
  endproperty
  a_nvm_wait: assert property (p_nvm_wait)
    else $error("NVM stopped while busy");

  property p_clk_first;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (state_q == ST_CLK_WAIT && !CLK_READY) |=> !stall_busy;
  endproperty
  a_clk_first: assert property (p_clk_first)
    else $error("stall began before clocks ready");

  property p_wake_end;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    $rose(WAKE_PULSE) |-> (!CPU_HOLD && $past(CPU_HOLD));
  endproperty
  a_wake_end: assert property (p_wake_end)
    else $error("wake pulse misaligned");

  property p_enter;
    @(posedge SYS_CLK) disable iff (SYS_RST)
    (state_q == ST_ACTIVE && SLEEP_EXEC && SLEEP_EN && !NVM_BUSY)
      |=> (SLEEP_ACTIVE && SLEEP_MODE_CUR == $past(SLEEP_MODE));
  endproperty
  a_enter: assert property (p_enter)
    else $error("sleep not entered");

endmodule

// file: src/smc_stall_cnt.sv
`timescale 1ns/1ps

// Down counter that holds the core for a fixed number of cycles
module smc_stall_cnt #(
  parameter int CYCLES = 4
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE  = CW'(1);
  localparam logic [CW-1:0] ZERO = '0;

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // Load on start, count down to zero
  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = LOAD;
    end else if (cnt_q != ZERO) begin
      cnt_d = cnt_q - ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy = (cnt_q != ZERO);
  assign done = (cnt_q == ONE);

endmodule

// file: tb/sleep_mode_controller_tb.sv
`timescale 1ns/1ps

module sleep_mode_controller_tb;
  logic              sys_clk  = 1'b0;
  logic              sys_rst  = 1'b1;
  logic              nvm_busy = 1'b0;
  logic              sexec;
  logic              sen;
  logic              chold;
  logic              sact;
  logic              wpulse;
  logic              crdy;
  logic [2:0]        smode;
  logic [2:0]        mcur;
  logic [3:0]        wreq;
  smc_pkg::smc_clk_t gate;
  int                miscompares = 0;
  int                comparisons = 0;
  logic [4:0]        gseen [5];
  logic [2:0]        modes [5] = '{smc_pkg::MODE_IDLE, smc_pkg::MODE_PDOWN,
    smc_pkg::MODE_PSAVE, smc_pkg::MODE_STANDBY, smc_pkg::MODE_XSTANDBY};

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  smc_sleep_ctrl i_smc_sleep_ctrl (
    .SYS_CLK        (sys_clk),
    .SYS_RST        (sys_rst),
    .SLEEP_EXEC     (sexec),
    .SLEEP_MODE     (smode),
    .SLEEP_EN       (sen),
    .CPU_HOLD       (chold),
    .SLEEP_ACTIVE   (sact),
    .SLEEP_MODE_CUR (mcur),
    .WAKE_REQ       (wreq),
    .WAKE_PULSE     (wpulse),
    .NVM_BUSY       (nvm_busy),
    .CLK_GATE       (gate),
    .CLK_READY      (crdy)
  );

  smc_core_model i_smc_core_model (
    .clk  (sys_clk),
    .exec (sexec),
    .mode (smode),
    .en   (sen),
    .wreq (wreq),
    .gate (gate),
    .rdy  (crdy)
  );

  // Compare and count
  task automatic check(input string what, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Gate bits each mode pins down; idle and power-down fully fixed
  function automatic logic [7:0] gmask(input logic [2:0] m);
    return (m == smc_pkg::MODE_IDLE || m == smc_pkg::MODE_PDOWN) ?
           8'h1F : 8'h18;
  endfunction

  function automatic logic [7:0] gexp(input logic [2:0] m);
    return (m == smc_pkg::MODE_IDLE) ? 8'h07 : 8'h00;
  endfunction

  // Outside idle a masked source first, then an allowed one; time the restart stall
  task automatic wake_up(input logic [2:0] m);
    int b;
    int r;
    int k;
    b = $urandom_range(3, (m == smc_pkg::MODE_IDLE) ? 0 : 1);
    i_smc_core_model.dly = $urandom_range(6, 0);
    if (m != smc_pkg::MODE_IDLE) begin
      i_smc_core_model.wreq = 4'h1;
      repeat (3) @(negedge sys_clk);
      check("masked", {7'h0, sact}, 8'h01);
    end
    i_smc_core_model.wreq = 4'h1 << b;
    @(negedge sys_clk);
    i_smc_core_model.wreq = 4'h0;
    check("awake", {7'h0, sact}, 8'h00);
    check("regate", {3'h0, gate}, 8'h1F);
    k = 0;
    r = -1;
    while (k < 60 && wpulse !== 1'b1) begin
      @(negedge sys_clk);
      k++;
      if (r < 0 && crdy === 1'b1) r = k;
    end
    check("stall", 8'(k - r), 8'(smc_pkg::STALL_CYCLES + 1));
    check("release", {7'h0, chold}, 8'h00);
    @(negedge sys_clk);
    check("pulse", {7'h0, wpulse}, 8'h00);
  endtask

  // Watchdog on a hang
  initial begin
    #20000;
    miscompares++;
    summarize();
  end

  initial begin
    logic [2:0] m;
    void'($urandom(32'h09E0));
    repeat (4) @(negedge sys_clk);
    sys_rst = 1'b0;
    i_smc_core_model.do_sleep(smc_pkg::MODE_IDLE, 1'b0);
    check("noop", {7'h0, chold}, 8'h00);
    // Every mode once, then random ones
    for (int i = 0; i < 15; i++) begin
      m = (i < 5) ? modes[i] : modes[$urandom_range(4, 0)];
      i_smc_core_model.do_sleep(m, 1'b1);
      check("hold", {7'h0, chold}, 8'h01);
      check("asleep", {7'h0, sact}, 8'h01);
      check("gate", {3'h0, gate} & gmask(m), gexp(m));
      // Remember the clock set of each mode on its first visit
      if (i < 5) begin
        gseen[i] = gate;
      end
      i_smc_core_model.do_sleep(~m, 1'b1);
      check("mode", {5'h0, mcur}, {5'h0, m});
      wake_up(m);
    end
    // Every pair of modes must stop a different clock set
    for (int p = 0; p < 5; p++) begin
      for (int q = p + 1; q < 5; q++) begin
        check("distinct", {7'h0, gseen[p] == gseen[q]}, 8'h00);
      end
    end
    // Programming in flight delays the stop
    nvm_busy = 1'b1;
    i_smc_core_model.do_sleep(smc_pkg::MODE_IDLE, 1'b1);
    repeat (3) @(negedge sys_clk);
    check("nvm", {6'h0, sact, gate.nvm_run}, 8'h01);
    nvm_busy = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("nvmdone", {7'h0, sact}, 8'h01);
    wake_up(smc_pkg::MODE_IDLE);
    // Reset while asleep
    i_smc_core_model.do_sleep(smc_pkg::MODE_PDOWN, 1'b1);
    sys_rst = 1'b1;
    @(negedge sys_clk);
    sys_rst = 1'b0;
    check("rst", {1'h0, chold, sact, gate}, 8'h1F);
    // A normal sleep and wake must still work after that reset
    i_smc_core_model.do_sleep(smc_pkg::MODE_IDLE, 1'b1);
    check("rehold", {7'h0, chold}, 8'h01);
    wake_up(smc_pkg::MODE_IDLE);
    summarize();
  end
endmodule

// file: tb/smc_core_model.sv
`timescale 1ns/1ps

// Core, interrupt controller and clock generator stand-in
module smc_core_model (
  // Clock
  input  wire logic              clk,
  // Core side
  output logic                   exec,
  output logic [2:0]             mode,
  output logic                   en,
  // Wake and clock side
  output logic [3:0]             wreq,
  input  wire smc_pkg::smc_clk_t gate,
  output logic                   rdy
);
  int dly = 0;
  int cnt = 0;

  // Quiet lines from time zero
  initial begin
    exec = 1'b0;
    mode = 3'h0;
    en   = 1'b0;
    wreq = 4'h0;
    rdy  = 1'b0;
  end

  // Software picks mode and moment; one-cycle instruction pulse
  task automatic do_sleep(input logic [2:0] m, input logic e);
    @(negedge clk);
    exec = 1'b1;
    mode = m;
    en   = e;
    @(negedge clk);
    exec = 1'b0;
  endtask

  // Ready only after gates are all on and a settling delay, prompt or slow
  always @(posedge clk) begin
    if (gate !== smc_pkg::CLK_ALL_ON) begin
      cnt <= 0;
      rdy <= 1'b0;
    end else if (cnt >= dly) begin
      rdy <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
